// ---- hdl/dsau_params.svh ----
// Address map, reset values and step sizes of the data-space access unit.
`ifndef DSAU_PARAMS_SVH
`define DSAU_PARAMS_SVH

// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define EA_WIDTH       16
`define NEAR_WIDTH     13
`define Y_BASE         16'h0C00
`define Y_END          16'h0FFF
`define IMPL_END       16'h0FFF

// ---------------------------------------------------------------
// Stack
// ---------------------------------------------------------------
`define SP_RESET       16'h0800
`define SP_FLOOR       16'h0800
`define LIMIT_RESET    16'h0000

// ---------------------------------------------------------------
// Steps, lanes and fill values
// ---------------------------------------------------------------
`define BYTE_STEP      16'h0001
`define WORD_STEP      16'h0002
`define ZERO_WORD      16'h0000
`define ZERO_BYTE      8'h00
`define LANE_LOW       2'h1
`define LANE_HIGH      2'h2
`define LANE_BOTH      2'h3

`endif

// ---- hdl/dsau_pkg.sv ----
// Types shared by the data-space access unit and its helpers.
package dsau_pkg;

  // Operation requested by the execution pipeline.
  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_WRITE     = 3'h1,
    OP_MAC_READ  = 3'h2,
    OP_ACC_WB    = 3'h3,
    OP_PUSH      = 3'h4,
    OP_POP       = 3'h5,
    OP_CALL_PUSH = 3'h6,
    OP_EXC_PUSH  = 3'h7
  } op_t;

  // How the X effective address is formed.
  typedef enum logic [1:0] {
    MODE_INDIRECT = 2'h0,
    MODE_NEAR13   = 2'h1,
    MODE_ABS16    = 2'h2
  } addr_mode_t;

  // Request facts carried along while memory answers.
  typedef struct packed {
    logic        valid;
    logic        rd;
    logic        byte_op;
    logic        lsb;
    logic        mac;
    logic        x_zero;
    logic        y_zero;
    logic        misalign;
    logic        stack_err;
    logic [15:0] reg_old;
    logic [15:0] ptr_next;
    logic [15:0] y_ptr_next;
  } meta_t;

endpackage

// ---- hdl/addr_region.sv ----
// Classifies one effective address against the fixed X and Y regions.
`timescale 1ns/1ps
`include "dsau_params.svh"

module addr_region #(
  parameter logic [15:0] Y_BASE   = `Y_BASE,
  parameter logic [15:0] Y_END    = `Y_END,
  parameter logic [15:0] IMPL_END = `IMPL_END
) (
  input  logic [15:0] ea,
  output logic        implemented,
  output logic        in_y
);

  // The map is fixed by parameters; software has no way to move it.
  // Y sits inside X, directly above the X-only RAM, so the whole
  // range reads as one linear space.
  assign implemented = (ea <= IMPL_END);
  assign in_y        = (ea >= Y_BASE) && (ea <= Y_END);

endmodule

// ---- hdl/stack_guard.sv ----
// Stack address, next pointer and stack error for one push or pop.
`timescale 1ns/1ps
`include "dsau_params.svh"

module stack_guard (
  input  logic [15:0] sp,
  input  logic [15:0] limit,
  input  logic        push,
  input  logic        pop,
  output logic [15:0] access_ea,
  output logic [15:0] sp_next,
  output logic        error
);

  // Push uses the free word then steps up; pop steps down first.
  always_comb begin
    access_ea = sp;
    sp_next   = sp;
    error     = 1'b0;
    if (push) begin
      access_ea = sp;
      sp_next   = sp + `WORD_STEP;
      // A push at the limit itself is allowed; only one beyond traps.
      error     = (sp > limit) || (sp < `SP_FLOOR);
    end else if (pop) begin
      access_ea = sp - `WORD_STEP;
      sp_next   = sp - `WORD_STEP;
      error     = (access_ea < `SP_FLOOR);
    end
  end

endmodule

// ---- hdl/dual_data_space_access_unit.sv ----
// Data-space access unit: X/Y routing, byte lanes, alignment and stack.
// How it works
// - Y region sits contiguously inside X.
// - Non-MAC instructions see one composite X space.
// - MAC reads: Y pointers for Y, X for X.
// - Dual X/Y reads only for MAC prefetch.
// - All writes go over the X write bus.
// - Accumulator write back may target any address.
// - Modulo in X and Y; bit-reverse X writes.
// - Invalid or cross-space reads return zero.
// - Effective addresses are 16-bit byte addresses.
// - X/Y boundary is fixed, not programmable.
// - Memory and registers are 16-bit words.
// - Byte reads select by bit 0, low lane.
// - Byte writes strobe only the matching lane.
// - Post-modify steps 1 for bytes, 2 words.
// - Misaligned read completes, misaligned write dropped; trap.
// - Byte loads keep the register's high byte.
// - Direct field 13 bits near, move 16 bits.
// - Stack grows up: post-increment push, pre-decrement pop.
// - Call pushes PC with upper byte cleared.
// - Exception pushes status low byte with PC.
// - Stack address below floor raises stack error.
// - Push beyond the stack limit raises stack error.
`timescale 1ns/1ps
`include "dsau_params.svh"

module dual_data_space_access_unit import dsau_pkg::*; #(
  parameter logic [15:0] Y_BASE   = `Y_BASE,
  parameter logic [15:0] Y_END    = `Y_END,
  parameter logic [15:0] IMPL_END = `IMPL_END
) (
  input  logic        mclk,
  input  logic        reset_n,
  input  logic        clk_en,
  input  logic        req_valid,
  input  op_t         req_op,
  input  logic        req_byte,
  input  addr_mode_t  req_mode,
  input  logic [15:0] req_field,
  input  logic [15:0] req_ptr,
  input  logic        req_post_inc,
  input  logic        req_post_dec,
  input  logic [15:0] req_y_ptr,
  input  logic        req_y_post_inc,
  input  logic        req_y_post_dec,
  input  logic [15:0] req_wdata,
  input  logic [15:0] req_reg_old,
  input  logic [7:0]  status_low_byte,
  input  logic        x_mod_en,
  input  logic        y_mod_en,
  input  logic [15:0] mod_start,
  input  logic [15:0] mod_end,
  input  logic        br_en,
  input  logic [15:0] br_modifier,
  input  logic        sp_load,
  input  logic [15:0] sp_load_value,
  input  logic        limit_load,
  input  logic [15:0] limit_load_value,
  input  logic [15:0] mem_x_rdata,
  input  logic [15:0] mem_y_rdata,
  output logic [15:0] mem_x_addr,
  output logic        mem_x_rd,
  output logic        mem_x_wr,
  output logic [1:0]  mem_x_be,
  output logic [15:0] mem_x_wdata,
  output logic [15:0] mem_y_addr,
  output logic        mem_y_rd,
  output logic        rsp_valid,
  output logic [15:0] rsp_x_data,
  output logic [15:0] rsp_y_data,
  output logic [15:0] rsp_reg_value,
  output logic [15:0] rsp_ptr_next,
  output logic [15:0] rsp_y_ptr_next,
  output logic        addr_err_trap,
  output logic        stack_err_trap,
  output logic [15:0] stack_pointer_reg,
  output logic [15:0] stack_limit_reg
);

  // ---------------------------------------------------------------
  // Pointer arithmetic
  // ---------------------------------------------------------------

  function automatic logic [15:0] bit_rev(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      bit_rev[i] = v[15 - i];
    end
  endfunction

  // Post-modify with optional modulo wrap or reversed-carry step.
  function automatic logic [15:0] next_pointer(
    input logic [15:0] ptr,
    input logic        inc,
    input logic        dec,
    input logic [15:0] step,
    input logic        mod_on,
    input logic        rev_on
  );
    logic [15:0] n;
    n = ptr;
    if (inc && rev_on) begin
      n = bit_rev(bit_rev(ptr) + bit_rev(br_modifier));
    end else if (inc) begin
      n = ptr + step;
      if (mod_on && ptr <= mod_end && n > mod_end) begin
        n = mod_start;
      end
    end else if (dec) begin
      n = ptr - step;
      if (mod_on && ptr == mod_start) begin
        n = mod_end + `BYTE_STEP - step;
      end
    end
    return n;
  endfunction

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------

  logic        take;
  logic        is_mac;
  logic        is_push;
  logic        is_pop;
  logic        is_wr;
  logic        is_rd;
  logic        byte_eff;
  logic [15:0] dir_ea;
  logic [15:0] stk_ea;
  logic [15:0] sp_next;
  logic        stk_err;
  logic [15:0] ea;
  logic        x_impl;
  logic        x_in_y;
  logic        y_impl;
  logic        y_in_y;
  logic        misalign;
  logic [15:0] step;
  logic [15:0] wdata;
  meta_t       next_a;
  meta_t       stage_a;
  meta_t       stage_b;

  assign take     = req_valid && clk_en;
  assign is_mac   = (req_op == OP_MAC_READ);
  assign is_push  = (req_op == OP_PUSH) || (req_op == OP_CALL_PUSH) ||
                    (req_op == OP_EXC_PUSH);
  assign is_pop   = (req_op == OP_POP);
  assign is_wr    = is_push || (req_op == OP_WRITE) || (req_op == OP_ACC_WB);
  assign is_rd    = is_pop || is_mac || (req_op == OP_READ);
  // Only plain moves carry byte size; DSP and stack work is word only.
  assign byte_eff = req_byte && (req_op == OP_READ || req_op == OP_WRITE);
  assign step     = byte_eff ? `BYTE_STEP : `WORD_STEP;

  // Near form reaches the low 8 Kbytes, absolute form everything.
  always_comb begin
    unique case (req_mode)
      MODE_NEAR13: dir_ea = {3'h0, req_field[`NEAR_WIDTH-1:0]};
      MODE_ABS16:  dir_ea = req_field;
      default:     dir_ea = req_ptr;
    endcase
  end

  stack_guard u_stack_guard (
    .sp        (stack_pointer_reg),
    .limit     (stack_limit_reg),
    .push      (is_push),
    .pop       (is_pop),
    .access_ea (stk_ea),
    .sp_next   (sp_next),
    .error     (stk_err)
  );

  // MAC reads always take their X address from an X pointer.
  assign ea = (is_push || is_pop) ? stk_ea : (is_mac ? req_ptr : dir_ea);

  addr_region #(.Y_BASE(Y_BASE), .Y_END(Y_END), .IMPL_END(IMPL_END)) u_x_region (
    .ea          (ea),
    .implemented (x_impl),
    .in_y        (x_in_y)
  );

  addr_region #(.Y_BASE(Y_BASE), .Y_END(Y_END), .IMPL_END(IMPL_END)) u_y_region (
    .ea          (req_y_ptr),
    .implemented (y_impl),
    .in_y        (y_in_y)
  );

  // Any word access at an odd byte address is flagged for an alignment trap.
  assign misalign = (!byte_eff && ea[0]) || (is_mac && req_y_ptr[0]);

  // Write word as it goes onto the X write bus.
  always_comb begin
    unique case (req_op)
      OP_WRITE:     wdata = byte_eff ? {2{req_wdata[7:0]}} : req_wdata;
      OP_CALL_PUSH: wdata = {`ZERO_BYTE, req_wdata[7:0]};
      OP_EXC_PUSH:  wdata = {status_low_byte, req_wdata[7:0]};
      default:      wdata = req_wdata;
    endcase
  end

  // Facts kept for the answer three cycles later.
  always_comb begin
    next_a            = '0;
    next_a.valid      = take;
    next_a.rd         = is_rd;
    next_a.byte_op    = byte_eff;
    next_a.lsb        = ea[0];
    next_a.mac        = is_mac;
    // Outside MAC class the Y block is just part of composite X.
    next_a.x_zero     = !x_impl || (is_mac && x_in_y);
    next_a.y_zero     = !y_impl || !y_in_y;
    next_a.misalign   = misalign;
    next_a.stack_err  = (is_push || is_pop) && stk_err;
    next_a.reg_old    = req_reg_old;
    // Reversed-carry stepping applies only to X writes.
    next_a.ptr_next   = next_pointer(req_ptr, req_post_inc, req_post_dec, step,
                                     x_mod_en, br_en && (req_op == OP_WRITE));
    next_a.y_ptr_next = next_pointer(req_y_ptr, req_y_post_inc, req_y_post_dec,
                                     `WORD_STEP, y_mod_en, 1'b0);
  end

  // ---------------------------------------------------------------
  // Memory strobes
  // ---------------------------------------------------------------

  // Strobes are one-cycle pulses; a stall holds them as they are.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_x_addr  <= `ZERO_WORD;
      mem_x_rd    <= 1'b0;
      mem_x_wr    <= 1'b0;
      mem_x_be    <= 2'h0;
      mem_x_wdata <= `ZERO_WORD;
      mem_y_addr  <= `ZERO_WORD;
      mem_y_rd    <= 1'b0;
    end else if (clk_en) begin
      // Word decode is shared by both lanes, so bit 0 never leaves.
      mem_x_addr  <= {ea[15:1], 1'b0};
      mem_x_rd    <= req_valid && is_rd && x_impl;
      // A misaligned write runs through but nothing is stored.
      mem_x_wr    <= req_valid && is_wr && x_impl && !misalign;
      if (byte_eff) begin
        mem_x_be <= ea[0] ? `LANE_HIGH : `LANE_LOW;
      end else begin
        mem_x_be <= `LANE_BOTH;
      end
      mem_x_wdata <= wdata;
      mem_y_addr  <= {req_y_ptr[15:1], 1'b0};
      // The Y path is read only, and only for MAC prefetch.
      mem_y_rd    <= req_valid && is_mac && y_impl && y_in_y;
    end
  end

  // ---------------------------------------------------------------
  // Pipeline of request facts
  // ---------------------------------------------------------------

  // Memory answers one cycle after its strobe, hence two stages.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage_a <= '0;
      stage_b <= '0;
    end else if (clk_en) begin
      stage_a <= next_a;
      stage_b <= stage_a;
    end
  end

  // ---------------------------------------------------------------
  // Answer
  // ---------------------------------------------------------------

  logic [15:0] x_word;
  logic [7:0]  x_byte;

  assign x_word = stage_b.x_zero ? `ZERO_WORD : mem_x_rdata;
  assign x_byte = stage_b.lsb ? x_word[15:8] : x_word[7:0];

  // Traps follow the completed instruction, together with its answer.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid      <= 1'b0;
      rsp_x_data     <= `ZERO_WORD;
      rsp_y_data     <= `ZERO_WORD;
      rsp_reg_value  <= `ZERO_WORD;
      rsp_ptr_next   <= `ZERO_WORD;
      rsp_y_ptr_next <= `ZERO_WORD;
      addr_err_trap  <= 1'b0;
      stack_err_trap <= 1'b0;
    end else if (clk_en) begin
      rsp_valid      <= stage_b.valid;
      rsp_ptr_next   <= stage_b.ptr_next;
      rsp_y_ptr_next <= stage_b.y_ptr_next;
      addr_err_trap  <= stage_b.valid && stage_b.misalign;
      stack_err_trap <= stage_b.valid && stage_b.stack_err;
      if (!stage_b.rd) begin
        rsp_x_data    <= `ZERO_WORD;
        rsp_reg_value <= `ZERO_WORD;
      end else if (stage_b.byte_op) begin
        rsp_x_data    <= {`ZERO_BYTE, x_byte};
        rsp_reg_value <= {stage_b.reg_old[15:8], x_byte};
      end else begin
        rsp_x_data    <= x_word;
        rsp_reg_value <= x_word;
      end
      if (stage_b.rd && stage_b.mac && !stage_b.y_zero) begin
        rsp_y_data <= mem_y_rdata;
      end else begin
        rsp_y_data <= `ZERO_WORD;
      end
    end
  end

  // ---------------------------------------------------------------
  // Stack pointer and limit
  // ---------------------------------------------------------------

  // Bit 0 is forced low because every stack access is a word.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stack_pointer_reg <= `SP_RESET;
    end else if (clk_en) begin
      if (sp_load) begin
        stack_pointer_reg <= {sp_load_value[15:1], 1'b0};
      end else if (req_valid && (is_push || is_pop)) begin
        stack_pointer_reg <= sp_next;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stack_limit_reg <= `LIMIT_RESET;
    end else if (clk_en && limit_load) begin
      stack_limit_reg <= {limit_load_value[15:1], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  property p_y_only_mac;
    take && !is_mac |=> !mem_y_rd;
  endproperty
  a_y_only_mac: assert property (p_y_only_mac) else $error("Y read outside MAC");

  property p_drop_misaligned_write;
    take && is_wr && misalign |=> !mem_x_wr;
  endproperty
  a_drop_misaligned_write: assert property (p_drop_misaligned_write)
    else $error("misaligned write reached memory");

  property p_trap_after_read;
    take && is_rd && misalign ##1 clk_en ##1 clk_en |=> addr_err_trap && rsp_valid;
  endproperty
  a_trap_after_read: assert property (p_trap_after_read)
    else $error("no address trap with answer");

  property p_byte_lane;
    take && is_wr && byte_eff |=>
      mem_x_be == ($past(ea[0]) ? `LANE_HIGH : `LANE_LOW);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("wrong byte lane");

  property p_mac_cross_zero;
    take && is_mac && x_in_y ##1 clk_en ##1 clk_en |=> rsp_x_data == `ZERO_WORD;
  endproperty
  a_mac_cross_zero: assert property (p_mac_cross_zero)
    else $error("cross-space MAC read not zero");

  property p_byte_step;
    take && byte_eff && req_post_inc && !x_mod_en && (is_rd || !br_en) ##1 clk_en ##1 clk_en
      |=> rsp_ptr_next == $past(req_ptr, 3) + `BYTE_STEP;
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("byte step not one");

  property p_push_step;
    take && is_push && !sp_load |=>
      stack_pointer_reg == $past(stack_pointer_reg) + `WORD_STEP;
  endproperty
  a_push_step: assert property (p_push_step) else $error("push did not step");

  property p_limit_equal;
    take && is_push && stack_pointer_reg == stack_limit_reg &&
      stack_pointer_reg >= `SP_FLOOR ##1 clk_en ##1 clk_en |=> !stack_err_trap;
  endproperty
  a_limit_equal: assert property (p_limit_equal)
    else $error("trap on push at limit");

  property p_call_upper;
    take && req_op == OP_CALL_PUSH |=> mem_x_wdata[15:8] == `ZERO_BYTE;
  endproperty
  a_call_upper: assert property (p_call_upper) else $error("call upper byte set");

  property p_exc_status;
    take && req_op == OP_EXC_PUSH |=>
      mem_x_wdata[15:8] == $past(status_low_byte);
  endproperty
  a_exc_status: assert property (p_exc_status) else $error("status byte lost");

  property p_byte_keep_high;
    take && is_rd && byte_eff ##1 clk_en ##1 clk_en |=>
      rsp_reg_value[15:8] == $past(req_reg_old[15:8], 3);
  endproperty
  a_byte_keep_high: assert property (p_byte_keep_high)
    else $error("byte load changed high byte");

  property p_near_range;
    take && req_mode == MODE_NEAR13 && !is_mac && !is_push && !is_pop
      |=> mem_x_addr < 16'h2000;
  endproperty
  a_near_range: assert property (p_near_range) else $error("near access out of range");

  c_mac_read: cover property (take && is_mac ##1 mem_y_rd && mem_x_rd);
  c_push:     cover property (take && is_push ##1 mem_x_wr);
  c_trap:     cover property (take && misalign ##3 addr_err_trap);

endmodule

// ---- testbench/data_mem_model.sv ----
// Behavioural data memory that answers the X and Y buses of the access unit.
`timescale 1ns/1ps

module data_mem_model (
  input  logic        mclk,
  input  logic [15:0] mem_x_addr,
  input  logic        mem_x_rd,
  input  logic        mem_x_wr,
  input  logic [1:0]  mem_x_be,
  input  logic [15:0] mem_x_wdata,
  input  logic [15:0] mem_y_addr,
  input  logic        mem_y_rd,
  output logic [15:0] mem_x_rdata,
  output logic [15:0] mem_y_rdata
);
  logic [15:0] mem [0:2047];

  // Each word holds a pattern of its own address, so a misrouted read shows.
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = {4'h0, i[10:0], 1'b0} ^ 16'hA55A;
    end
    mem_x_rdata = 16'h0000;
    mem_y_rdata = 16'h0000;
  end

  // Lanes are written apart; read data follows the strobe by one cycle.
  always @(posedge mclk) begin
    if (mem_x_wr && mem_x_be[0]) mem[mem_x_addr[11:1]][7:0] <= mem_x_wdata[7:0];
    if (mem_x_wr && mem_x_be[1]) mem[mem_x_addr[11:1]][15:8] <= mem_x_wdata[15:8];
    // Outside a read the bus toggles, so a stale word cannot pass as an answer.
    mem_x_rdata <= mem_x_rd ? mem[mem_x_addr[11:1]] : ~mem_x_rdata;
    mem_y_rdata <= mem_y_rd ? mem[mem_y_addr[11:1]] : ~mem_y_rdata;
  end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench of the data-space access unit with a memory model.
`timescale 1ns/1ps
`define CHECK_EQ(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module testbench import dsau_pkg::*; ;
  typedef struct { logic [15:0] x, y, r, p, q; logic ae, se; logic [3:0] chk; } note_t;
  logic        mclk;
  logic        reset_n = 1'b0, clk_en = 1'b1, req_valid = 1'b0, req_byte = 1'b0;
  op_t         req_op = OP_READ;
  addr_mode_t  req_mode = MODE_INDIRECT;
  logic [15:0] req_field = 16'h0000, req_ptr = 16'h0000, req_y_ptr = 16'h0000;
  logic [15:0] req_wdata = 16'h0000, req_reg_old = 16'h0000, br_modifier = 16'h0000;
  logic        req_post_inc = 1'b0, req_post_dec = 1'b0, req_y_post_inc = 1'b0;
  logic        req_y_post_dec = 1'b0, x_mod_en = 1'b0, y_mod_en = 1'b0, br_en = 1'b0;
  logic [7:0]  status_low_byte = 8'h00, st;
  logic [15:0] mod_start = 16'h0900, mod_end = 16'h090F, yp = 16'h0000, a;
  logic        sp_load = 1'b0, limit_load = 1'b0;
  logic [15:0] sp_load_value = 16'h0000, limit_load_value = 16'h0000;
  logic [15:0] mem_x_rdata, mem_y_rdata, mem_x_addr, mem_x_wdata, mem_y_addr;
  logic        mem_x_rd, mem_x_wr, mem_y_rd, rsp_valid, addr_err_trap, stack_err_trap;
  logic [1:0]  mem_x_be;
  logic [15:0] rsp_x_data, rsp_y_data, rsp_reg_value, rsp_ptr_next, rsp_y_ptr_next;
  logic [15:0] stack_pointer_reg, stack_limit_reg;
  note_t       notes[$];
  note_t       seen;
  int          n_errors = 0;
  int          n_compared = 0;

  dual_data_space_access_unit uut (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid),
    .req_op(req_op), .req_byte(req_byte), .req_mode(req_mode), .req_field(req_field),
    .req_ptr(req_ptr), .req_post_inc(req_post_inc), .req_post_dec(req_post_dec),
    .req_y_ptr(req_y_ptr), .req_y_post_inc(req_y_post_inc),
    .req_y_post_dec(req_y_post_dec), .req_wdata(req_wdata), .req_reg_old(req_reg_old),
    .status_low_byte(status_low_byte), .x_mod_en(x_mod_en), .y_mod_en(y_mod_en),
    .mod_start(mod_start), .mod_end(mod_end), .br_en(br_en), .br_modifier(br_modifier),
    .sp_load(sp_load), .sp_load_value(sp_load_value), .limit_load(limit_load),
    .limit_load_value(limit_load_value), .mem_x_rdata(mem_x_rdata),
    .mem_y_rdata(mem_y_rdata), .mem_x_addr(mem_x_addr), .mem_x_rd(mem_x_rd),
    .mem_x_wr(mem_x_wr), .mem_x_be(mem_x_be), .mem_x_wdata(mem_x_wdata),
    .mem_y_addr(mem_y_addr), .mem_y_rd(mem_y_rd), .rsp_valid(rsp_valid),
    .rsp_x_data(rsp_x_data), .rsp_y_data(rsp_y_data), .rsp_reg_value(rsp_reg_value),
    .rsp_ptr_next(rsp_ptr_next), .rsp_y_ptr_next(rsp_y_ptr_next),
    .addr_err_trap(addr_err_trap), .stack_err_trap(stack_err_trap),
    .stack_pointer_reg(stack_pointer_reg), .stack_limit_reg(stack_limit_reg));

  data_mem_model memory (
    .mclk(mclk), .mem_x_addr(mem_x_addr), .mem_x_rd(mem_x_rd), .mem_x_wr(mem_x_wr),
    .mem_x_be(mem_x_be), .mem_x_wdata(mem_x_wdata), .mem_y_addr(mem_y_addr),
    .mem_y_rd(mem_y_rd), .mem_x_rdata(mem_x_rdata), .mem_y_rdata(mem_y_rdata));

  // Contents the memory model starts with at a word address.
  function automatic logic [15:0] pat(input logic [15:0] w);
    return {w[15:1], 1'b0} ^ 16'hA55A;
  endfunction

  // One request per call, launched on a falling edge, with its expected answer queued.
  task automatic issue(input op_t op, input logic b, input addr_mode_t m,
    input logic [15:0] f, p, w, input logic inc, input logic [15:0] ex, ey,
    input logic ae, se, input logic [3:0] chk);
    note_t n;
    @(negedge mclk);
    req_valid = 1'b1;
    req_op = op;
    req_byte = b;
    req_mode = m;
    req_field = f;
    req_ptr = p;
    req_wdata = w;
    req_post_inc = inc;
    req_post_dec = inc & 1'($urandom);
    req_y_ptr = yp;
    req_y_post_inc = 1'($urandom);
    req_reg_old = 16'($urandom);
    status_low_byte = 8'($urandom);
    // Reversal only acts on writes, so random settings must not move a read pointer.
    br_en = 1'($urandom);
    br_modifier = 16'($urandom);
    n.x = b ? {8'h00, p[0] ? ex[15:8] : ex[7:0]} : ex;
    n.y = ey;
    n.r = b ? {req_reg_old[15:8], n.x[7:0]} : n.x;
    n.p = p + (inc ? (b ? 16'h0001 : 16'h0002) : 16'h0000);
    if (x_mod_en && inc && n.p > mod_end) n.p = mod_start;
    n.q = yp + (req_y_post_inc ? 16'h0002 : 16'h0000);
    n.ae = ae;
    n.se = se;
    n.chk = chk;
    notes.push_back(n);
  endtask

  task automatic rd(input logic b, input logic [15:0] p, input logic inc,
    input logic [15:0] ex, input logic ae);
    issue(OP_READ, b, MODE_INDIRECT, 16'h0000, p, 16'h0000, inc, ex, 16'h0000, ae, 1'b0, 4'hD);
  endtask

  task automatic stk(input op_t op, input logic [15:0] w, ex, input logic se, input logic c);
    issue(op, 1'b0, MODE_INDIRECT, 16'h0000, 16'h0000, w, 1'b0, ex, 16'h0000, 1'b0, se, {3'h0, c});
  endtask

  task automatic idle(input int n);
    @(negedge mclk);
    req_valid = 1'b0;
    repeat (n) @(negedge mclk);
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Each answer takes the oldest note; answers come back in request order.
  // Sampled mid-cycle so the answer has settled after its launching edge.
  always @(negedge mclk) begin
    if (reset_n === 1'b1 && rsp_valid === 1'b1) begin
      `CHECK_EQ("queue holds a note", 1'b1, notes.size() > 0)
      if (notes.size() > 0) begin
        seen = notes.pop_front();
        if (seen.chk[0]) `CHECK_EQ("rsp_x_data", seen.x, rsp_x_data)
        if (seen.chk[1]) `CHECK_EQ("rsp_y_data", seen.y, rsp_y_data)
        if (seen.chk[2]) `CHECK_EQ("rsp_reg_value", seen.r, rsp_reg_value)
        if (seen.chk[3]) `CHECK_EQ("rsp_ptr_next", seen.p, rsp_ptr_next)
        `CHECK_EQ("rsp_y_ptr_next", seen.q, rsp_y_ptr_next)
        `CHECK_EQ("addr_err_trap", seen.ae, addr_err_trap)
        `CHECK_EQ("stack_err_trap", seen.se, stack_err_trap)
      end
    end
  end

  // The whole sequence needs under a hundred cycles; this bound only catches a hang.
  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(81));
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    `CHECK_EQ("stack_pointer_reg", 16'h0800, stack_pointer_reg)
    `CHECK_EQ("stack_limit_reg", 16'h0000, stack_limit_reg)
    sp_load = 1'b1;
    sp_load_value = 16'h0900;
    limit_load = 1'b1;
    limit_load_value = 16'h0906;
    @(negedge mclk);
    sp_load = 1'b0;
    limit_load = 1'b0;
    rd(1'b0, 16'h0802, 1'b1, pat(16'h0802), 1'b0);
    rd(1'b1, 16'h0803, 1'b1, pat(16'h0802), 1'b0);
    rd(1'b0, 16'h0805, 1'b1, pat(16'h0804), 1'b1);
    issue(OP_READ, 0, MODE_NEAR13, 16'hE810, 0, 0, 0, pat(16'h0810), 0, 0, 0, 4'h1);
    issue(OP_READ, 0, MODE_ABS16, 16'h2000, 0, 0, 0, 16'h0000, 0, 0, 0, 4'h1);
    issue(OP_WRITE, 1, MODE_INDIRECT, 0, 16'h0803, 16'h005A, 0, 0, 0, 0, 0, 4'h0);
    issue(OP_WRITE, 0, MODE_INDIRECT, 0, 16'h0807, 16'hFFFF, 0, 0, 0, 1, 0, 4'h0);
    issue(OP_ACC_WB, 0, MODE_INDIRECT, 0, 16'h0C20, 16'hBEEF, 0, 0, 0, 0, 0, 4'h0);
    rd(1'b0, 16'h0802, 1'b0, 16'h5A00 | (pat(16'h0802) & 16'h00FF), 1'b0);
    rd(1'b0, 16'h0806, 1'b0, pat(16'h0806), 1'b0);
    rd(1'b0, 16'h0C20, 1'b0, 16'hBEEF, 1'b0);
    yp = 16'h0C20;
    issue(OP_MAC_READ, 0, MODE_INDIRECT, 0, 16'h0A00, 0, 0, pat(16'h0A00), 16'hBEEF,
          0, 0, 4'h3);
    yp = 16'h0900;
    issue(OP_MAC_READ, 0, MODE_INDIRECT, 0, 16'h0C00, 0, 0, 0, 0, 0, 0, 4'h3);
    x_mod_en = 1'b1;
    rd(1'b0, 16'h090E, 1'b1, pat(16'h090E), 1'b0);
    idle(1);
    x_mod_en = 1'b0;
    stk(OP_PUSH, 16'h1234, 0, 1'b0, 1'b0);
    stk(OP_CALL_PUSH, 16'hFFAB, 0, 1'b0, 1'b0);
    stk(OP_EXC_PUSH, 16'hFFAB, 0, 1'b0, 1'b0);
    st = status_low_byte;
    stk(OP_PUSH, 16'h1111, 0, 1'b0, 1'b0);
    stk(OP_PUSH, 16'h2222, 0, 1'b1, 1'b0);
    idle(2);
    `CHECK_EQ("stack_pointer_reg", 16'h090A, stack_pointer_reg)
    stk(OP_POP, 0, 16'h2222, 1'b0, 1'b1);
    stk(OP_POP, 0, 16'h1111, 1'b0, 1'b1);
    stk(OP_POP, 0, {st, 8'hAB}, 1'b0, 1'b1);
    stk(OP_POP, 0, 16'h00AB, 1'b0, 1'b1);
    stk(OP_POP, 0, 16'h1234, 1'b0, 1'b1);
    idle(2);
    `CHECK_EQ("stack_pointer_reg", 16'h0900, stack_pointer_reg)
    sp_load = 1'b1;
    sp_load_value = 16'h0800;
    @(negedge mclk);
    sp_load = 1'b0;
    stk(OP_POP, 0, pat(16'h07FE), 1'b1, 1'b1);
    repeat (24) begin
      a = 16'h0A00 | (16'($urandom) & 16'h01FE);
      rd(1'b0, a, 1'($urandom), pat(a), 1'b0);
    end
    idle(6);
    `CHECK_EQ("notes left", 0, notes.size())
    give_verdict();
  end
endmodule
